// >>> hw/rosd_delay.sv
`timescale 1ns/1ps
`default_nettype none
module rosd_delay
    import rosd_pkg::*;
#(
    parameter int W = DELAY_W
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic         src,
    input  wire logic [W-1:0] on_ticks,
    input  wire logic [W-1:0] off_ticks,
    output logic              out
);

    // ****************************************************************
    // On and off delay timer
    // ****************************************************************
    logic [W-1:0] cnt_q;
    logic         out_q;
    wire          differ   = (src != out_q);
    wire  [W-1:0] target   = src ? on_ticks : off_ticks;
    wire          zero_dly = (target == '0);
    wire          expire   = tick && (cnt_q + W'(1) >= target);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else if (!differ) begin
            cnt_q <= '0;
        end else if (zero_dly || expire) begin
            out_q <= src;
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign out = out_q;

    chk_zero_follow: assert property (@(posedge clk) disable iff (!rst_n)
        (differ && zero_dly) |=> (out_q == $past(src)))
        else $error("zero delay did not follow source");

    chk_cancel_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (!differ) |=> (out_q == $past(out_q)))
        else $error("output changed without pending difference");

endmodule : rosd_delay
`default_nettype wire

// >>> hw/rosd_pkg.sv
// How it works
// - Code 23 selects bit 11 of drive status word one.
// - Code 24 selects bit 9 of the main status word.
// - Code 25 selects the external charge complete flag.
// - Codes 27 to 29 select timed-function bits 0 to 2.
// - Reserved codes 30 to 32 select timed-function bits 3 to 5.
// - Codes 33 to 35 select supervision bits 0 to 2.
// - Code 39 selects bit 13 of drive status word two.
// - Codes 40 to 42 select output control word bits 0 to 2.
// - A bit pointer may select any single bit as source instead.
// - Relay one turns on after a programmable delay, 0.0 to 3000.0 s in 0.1 s.
// - Relay one turns off after a separate programmable delay, same range.
// - Control word bits 0, 1, 2 are each selectable as the source for relay one.
package rosd_pkg;

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam logic [5:0]  SEL_EXT2        = 6'h17;
    localparam logic [5:0]  SEL_REMOTE      = 6'h18;
    localparam logic [5:0]  SEL_CHARGE      = 6'h19;
    localparam logic [5:0]  SEL_TIMED_LO    = 6'h1B;
    localparam logic [5:0]  SEL_TIMED_HI    = 6'h20;
    localparam logic [5:0]  SEL_SUPV_LO     = 6'h21;
    localparam logic [5:0]  SEL_SUPV_HI     = 6'h23;
    localparam logic [5:0]  SEL_START_DLY   = 6'h27;
    localparam logic [5:0]  SEL_CTRL_LO     = 6'h28;
    localparam logic [5:0]  SEL_CTRL_HI     = 6'h2A;
    localparam logic [5:0]  SEL_POINTER     = 6'h3F;
    localparam int          BIT_EXT2        = 11;
    localparam int          BIT_REMOTE      = 9;
    localparam int          BIT_START_DLY   = 13;
    localparam logic [15:0] CTRL_WORD_RESET = 16'h0000;
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          TICK_MS         = 100;
    localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int          DELAY_MAX_TICKS = 30000;
    localparam int          DELAY_W         = 15;
    localparam int          PTR_W           = 6;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [15:0] status_word_one;
        logic [15:0] main_status;
        logic [15:0] status_word_two;
        logic [15:0] timed_status;
        logic [15:0] supervision;
        logic        charge_complete;
    } rosd_status_t;

    typedef struct packed {
        logic [DELAY_W-1:0] on_ticks;
        logic [DELAY_W-1:0] off_ticks;
    } rosd_delay_t;

endpackage : rosd_pkg

// >>> hw/rosd_top.sv
`timescale 1ns/1ps
`default_nettype none
module rosd_top
    import rosd_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire rosd_status_t       status,
    input  wire logic               ctrl_wr,
    input  wire logic [15:0]        ctrl_wdata,
    output logic      [15:0]        output_control_word,
    input  wire logic [PTR_W-1:0]   source_select,
    input  wire logic [6:0]         pointer_bit,
    input  wire rosd_delay_t        delays,
    output logic                    relay_output_one,
    output logic                    source_level
);

    // ****************************************************************
    // Reset synchroniser
    // ****************************************************************
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ****************************************************************
    // Output control word
    // ****************************************************************
    logic [15:0] ctrl_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= CTRL_WORD_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= ctrl_wdata;
        end
    end

    assign output_control_word = ctrl_q;

    // ****************************************************************
    // Source selector
    // ****************************************************************
    wire [96:0] flat_bits = {ctrl_q, status};
    wire [5:0]  t_idx     = source_select - SEL_TIMED_LO;
    wire [5:0]  s_idx     = source_select - SEL_SUPV_LO;
    wire [5:0]  c_idx     = source_select - SEL_CTRL_LO;
    wire        in_timed  = (source_select >= SEL_TIMED_LO) && (source_select <= SEL_TIMED_HI);
    wire        in_supv   = (source_select >= SEL_SUPV_LO) && (source_select <= SEL_SUPV_HI);
    wire        in_ctrl   = (source_select >= SEL_CTRL_LO) && (source_select <= SEL_CTRL_HI);
    wire        ptr_ok    = (pointer_bit < 7'h61);
    logic       sel_src;

    always_comb begin
        sel_src = 1'b0;
        if (source_select == SEL_EXT2) begin
            sel_src = status.status_word_one[BIT_EXT2];
        end else if (source_select == SEL_REMOTE) begin
            sel_src = status.main_status[BIT_REMOTE];
        end else if (source_select == SEL_CHARGE) begin
            sel_src = status.charge_complete;
        end else if (in_timed) begin
            sel_src = status.timed_status[t_idx[3:0]];
        end else if (in_supv) begin
            sel_src = status.supervision[s_idx[3:0]];
        end else if (source_select == SEL_START_DLY) begin
            sel_src = status.status_word_two[BIT_START_DLY];
        end else if (in_ctrl) begin
            sel_src = ctrl_q[c_idx[3:0]];
        end else if (source_select == SEL_POINTER && ptr_ok) begin
            sel_src = flat_bits[pointer_bit];
        end
    end

    logic src_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            src_q <= 1'b0;
        end else begin
            src_q <= sel_src;
        end
    end

    assign source_level = src_q;

    // ****************************************************************
    // Tick generator, 0.1 s
    // ****************************************************************
    logic [31:0] tick_cnt_q;
    wire         tick = (tick_cnt_q == 32'(TICK_CYC - 1));

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end

    // ****************************************************************
    // Relay one delay
    // ****************************************************************
    rosd_delay #(.W(DELAY_W)) u_delay (
        .clk       (clk),
        .rst_n     (rst_n_q),
        .tick      (tick),
        .src       (src_q),
        .on_ticks  (delays.on_ticks),
        .off_ticks (delays.off_ticks),
        .out       (relay_output_one)
    );

    chk_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n_q)
        ctrl_wr |=> (output_control_word == $past(ctrl_wdata)))
        else $error("control word write lost");

    chk_ctrl_bit0: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_CTRL_LO) |=> (src_q == $past(ctrl_q[0])))
        else $error("control bit 0 not routed");

    chk_ext2_route: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_EXT2) |=> (src_q == $past(status.status_word_one[BIT_EXT2])))
        else $error("second location bit not routed");

    chk_remote_rt: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_REMOTE) |=> (src_q == $past(status.main_status[BIT_REMOTE])))
        else $error("remote bit not routed");

    chk_timed_res: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_TIMED_HI) |=> (src_q == $past(status.timed_status[5])))
        else $error("reserved timed bit not routed");

    chk_supv_top: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_SUPV_HI) |=> (src_q == $past(status.supervision[2])))
        else $error("supervision bit 2 not routed");

    chk_start_dly: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_START_DLY) |=> (src_q == $past(status.status_word_two[BIT_START_DLY])))
        else $error("start delay bit not routed");

    chk_relay_stable: assert property (@(posedge clk) disable iff (!rst_n_q)
        (!tick && relay_output_one != $past(relay_output_one)) |->
        ($past(src_q) == relay_output_one))
        else $error("relay changed against its source");

    // ****************************************************************
    // Fixed code routing and control word hold checks
    // ****************************************************************
    chk_charge_route: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_CHARGE)
        |=> (src_q == $past(status.charge_complete)))
        else $error("charge flag not routed");

    chk_timed_bit0: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_TIMED_LO)
        |=> (src_q == $past(status.timed_status[0])))
        else $error("timed bit 0 not routed");

    chk_timed_bit1: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == 6'h1C)
        |=> (src_q == $past(status.timed_status[1])))
        else $error("timed bit 1 not routed");

    chk_timed_bit2: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == 6'h1D)
        |=> (src_q == $past(status.timed_status[2])))
        else $error("timed bit 2 not routed");

    chk_timed_res3: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == 6'h1E)
        |=> (src_q == $past(status.timed_status[3])))
        else $error("reserved timed bit 3 not routed");

    chk_timed_res4: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == 6'h1F)
        |=> (src_q == $past(status.timed_status[4])))
        else $error("reserved timed bit 4 not routed");

    chk_supv_bit0: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_SUPV_LO)
        |=> (src_q == $past(status.supervision[0])))
        else $error("supervision bit 0 not routed");

    chk_supv_bit1: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == 6'h22)
        |=> (src_q == $past(status.supervision[1])))
        else $error("supervision bit 1 not routed");

    chk_ctrl_bit1: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == 6'h29)
        |=> (src_q == $past(ctrl_q[1])))
        else $error("control bit 1 not routed");

    chk_ctrl_bit2: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_CTRL_HI)
        |=> (src_q == $past(ctrl_q[2])))
        else $error("control bit 2 not routed");

    chk_unknown_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == 6'h1A)
        |=> (src_q == 1'b0))
        else $error("unknown code gave a set source");

    chk_ctrl_hold: assert property (@(posedge clk) disable iff (!rst_n_q)
        (!ctrl_wr)
        |=> (output_control_word == $past(output_control_word)))
        else $error("control word changed without write");

    // ****************************************************************
    // Pointer, tick and relay checks
    // ****************************************************************
    chk_ptr_ctrl: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_POINTER && pointer_bit == 7'h51)
        |=> (src_q == $past(ctrl_q[0])))
        else $error("pointer to control bit 0 failed");

    chk_ptr_charge: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_POINTER && pointer_bit == 7'h00)
        |=> (src_q == $past(status.charge_complete)))
        else $error("pointer to charge flag failed");

    chk_ptr_ext2: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_POINTER && pointer_bit == 7'h4C)
        |=> (src_q == $past(status.status_word_one[BIT_EXT2])))
        else $error("pointer to second location bit failed");

    chk_ptr_remote: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_POINTER && pointer_bit == 7'h3A)
        |=> (src_q == $past(status.main_status[BIT_REMOTE])))
        else $error("pointer to remote bit failed");

    chk_ptr_start: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_POINTER && pointer_bit == 7'h2E)
        |=> (src_q == $past(status.status_word_two[BIT_START_DLY])))
        else $error("pointer to start delay bit failed");

    chk_ptr_timed: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_POINTER && pointer_bit == 7'h11)
        |=> (src_q == $past(status.timed_status[0])))
        else $error("pointer to timed bit 0 failed");

    chk_ptr_supv: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_POINTER && pointer_bit == 7'h01)
        |=> (src_q == $past(status.supervision[0])))
        else $error("pointer to supervision bit 0 failed");

    chk_ptr_range: assert property (@(posedge clk) disable iff (!rst_n_q)
        (source_select == SEL_POINTER && pointer_bit >= 7'h61)
        |=> (src_q == 1'b0))
        else $error("pointer out of range gave a set source");

    chk_tick_single: assert property (@(posedge clk) disable iff (!rst_n_q)
        tick
        |=> (!tick))
        else $error("tick lasted more than one cycle");

    chk_tick_bound: assert property (@(posedge clk) disable iff (!rst_n_q)
        1'b1
        |-> (tick_cnt_q < 32'(TICK_CYC)))
        else $error("tick counter passed its period");

    chk_on_at_tick: assert property (@(posedge clk) disable iff (!rst_n_q)
        ($rose(relay_output_one) && $past(delays.on_ticks) != '0)
        |-> $past(tick))
        else $error("delayed turn on away from a tick");

    chk_off_at_tick: assert property (@(posedge clk) disable iff (!rst_n_q)
        ($fell(relay_output_one) && $past(delays.off_ticks) != '0)
        |-> $past(tick))
        else $error("delayed turn off away from a tick");

    chk_rise_source: assert property (@(posedge clk) disable iff (!rst_n_q)
        $rose(relay_output_one)
        |-> $past(src_q))
        else $error("relay rose with source low");

    chk_fall_source: assert property (@(posedge clk) disable iff (!rst_n_q)
        $fell(relay_output_one)
        |-> !$past(src_q))
        else $error("relay fell with source high");

    chk_zero_on: assert property (@(posedge clk) disable iff (!rst_n_q)
        (delays.on_ticks == '0 && src_q && !relay_output_one)
        |=> relay_output_one)
        else $error("zero on delay did not follow");

    chk_zero_off: assert property (@(posedge clk) disable iff (!rst_n_q)
        (delays.off_ticks == '0 && !src_q && relay_output_one)
        |=> !relay_output_one)
        else $error("zero off delay did not follow");

endmodule : rosd_top
`default_nettype wire

// >>> tb/rosd_master.sv
`timescale 1ns/1ps
`default_nettype none
module rosd_master (
    input  wire logic        clk,
    output var  logic        ctrl_wr,
    output var  logic [15:0] ctrl_wdata
);
    // ****************************************************************
    // Fieldbus master writing the output control word
    // ****************************************************************
    initial begin
        ctrl_wr    = 1'b0;
        ctrl_wdata = 16'h0000;
    end
    // Whole 16-bit word aimed at the control word
    task automatic write_word(input logic [15:0] w);
        @(posedge clk);
        ctrl_wr    <= 1'b1;
        ctrl_wdata <= w;
        @(posedge clk);
        ctrl_wr    <= 1'b0;
        ctrl_wdata <= ~w;
    endtask : write_word
endmodule : rosd_master
`default_nettype wire

// >>> tb/rosd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rosd_top_tb;
    import rosd_pkg::*;
    // ****************************************************************
    // Bench
    // ****************************************************************
    logic         clk;
    logic         resetn;
    rosd_status_t status;
    logic         ctrl_wr;
    logic [15:0]  ctrl_wdata;
    logic [15:0]  output_control_word;
    logic [5:0]   source_select;
    logic [6:0]   pointer_bit;
    rosd_delay_t  delays;
    logic         relay_output_one;
    logic         source_level;
    int           fails;
    int           check_count;

    rosd_master mst (.clk(clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata));
    rosd_top #(.TICK_CYC(10)) rosd_top_inst (
        .clk(clk), .resetn(resetn), .status(status), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .output_control_word(output_control_word),
        .source_select(source_select), .pointer_bit(pointer_bit), .delays(delays),
        .relay_output_one(relay_output_one), .source_level(source_level));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (e !== g) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic report_and_stop();
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // Inverse pattern gives 0, one-hot gives 1, fixed code then pointer
    task automatic sel_case(input logic [5:0] code, input int idx);
        logic [96:0] m;
        m = 97'h1 << idx;
        for (int p = 0; p < 2; p++) begin
            for (int v = 0; v < 2; v++) begin
                source_select <= p ? SEL_POINTER : code;
                pointer_bit   <= 7'(idx);
                status        <= v ? m[80:0] : ~m[80:0];
                if (idx > 80) mst.write_word(v ? m[96:81] : ~m[96:81]);
                cyc(4);
                chk("source_level", 16'(v), 16'(source_level));
                chk("relay_zero_delay", 16'(v), 16'(relay_output_one));
            end
        end
    endtask : sel_case

    // Activation, deactivation and cancelled activation on one tick scale
    task automatic delay_case(input int n_on, input int n_off);
        delays <= '{on_ticks: 15'(n_on), off_ticks: 15'(n_off)};
        source_select <= SEL_CHARGE;
        status <= '{charge_complete: 1'b1, default: 16'h0000};
        cyc(2);
        chk("source_level", 16'h0001, 16'(source_level));
        cyc(n_on * 10 - 12);
        chk("relay_on_early", 16'h0000, 16'(relay_output_one));
        cyc(13);
        chk("relay_on", 16'h0001, 16'(relay_output_one));
        status <= '0;
        cyc(n_off * 10 - 10);
        chk("relay_off_early", 16'h0001, 16'(relay_output_one));
        cyc(13);
        chk("relay_off", 16'h0000, 16'(relay_output_one));
        status <= '{charge_complete: 1'b1, default: 16'h0000};
        cyc(5);
        status <= '0;
        cyc(n_on * 10 + 10);
        chk("relay_cancel", 16'h0000, 16'(relay_output_one));
    endtask : delay_case

    initial begin
        #100us;
        fails++;
        report_and_stop();
    end

    initial begin
        fails = 0;
        check_count = 0;
        resetn = 1'b0;
        status = '0;
        source_select = 6'h00;
        pointer_bit = 7'h00;
        delays = '0;
        cyc(4);
        resetn <= 1'b1;
        cyc(3);
        chk("output_control_word", CTRL_WORD_RESET, output_control_word);
        status <= '1;
        source_select <= 6'h1A;
        cyc(4);
        chk("unknown_code", 16'h0000, 16'(source_level));
        sel_case(SEL_EXT2, 65 + BIT_EXT2);
        sel_case(SEL_REMOTE, 49 + BIT_REMOTE);
        sel_case(SEL_CHARGE, 0);
        sel_case(SEL_START_DLY, 33 + BIT_START_DLY);
        for (int k = 0; k < 6; k++) sel_case(SEL_TIMED_LO + 6'(k), 17 + k);
        for (int k = 0; k < 3; k++) sel_case(SEL_SUPV_LO + 6'(k), 1 + k);
        for (int k = 0; k < 3; k++) sel_case(SEL_CTRL_LO + 6'(k), 81 + k);
        chk("output_control_word", 16'h0004, output_control_word);
        status <= '0;
        source_select <= 6'h00;
        cyc(4);
        delay_case(3, 2);
        report_and_stop();
    end
endmodule : rosd_top_tb
`default_nettype wire
